// ---- link_phy_init_config.sv ----
// link PHY configuration, CDR wait, reconnect timers, config decode
// assumes bus strobes and init start come from the i_clk domain;
// CDR lock arrives from the PHY on i_link_clk, LDT from a pin
`timescale 1ns/10ps
module link_phy_init_config
  import link_phy_pkg::*;
(
  // clocks and reset
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_ce,
  input  wire logic               i_link_clk,
  // register port
  input  wire logic [11:0]        i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [31:0]        o_rdata,
  // operating mode
  input  wire logic               i_wide_mode,
  input  wire logic               i_legacy_mode,
  input  wire logic               i_soft_freq_en,
  // pads
  output pad_cfg_type             o_pad_lo,
  output pad_cfg_type             o_pad_hi,
  // link initialization
  input  wire logic               i_init_start,
  input  wire logic               i_phy_cdr_lock,
  output logic                    o_cdr_done,
  output logic                    o_link_cdr_done,
  // reconnect after frequency change
  input  wire logic               i_ldt_active,
  output logic                    o_rx_reconnect_done,
  output logic                    o_tx_reconnect_done,
  // configuration space decode
  input  wire logic               i_cpu_req,
  input  wire logic [39:0]        i_cpu_addr,
  output cfg_req_type             o_cfg_req,
  // inter-chip routing
  input  wire logic               i_route_req,
  input  wire logic [1:0]         i_my_id,
  input  wire logic [1:0]         i_dst_id,
  output logic      [1:0]         o_next_id,
  output logic                    o_route_local,
  output logic                    o_route_high_half,
  output logic                    o_low_half_master
);

  function automatic pad_cfg_type word_to_pad(input logic [31:0] w);
    word_to_pad = pad_cfg_type'({w[31:20], w[16:12]});
  endfunction

  function automatic logic [31:0] pad_to_word(input pad_cfg_type p);
    pad_to_word = {p[16:5], 3'h0, p[4:0], 12'h000};
  endfunction

  // X is the low id bit, Y the high one
  function automatic logic [1:0] next_hop(input logic [1:0] me,
                                          input logic [1:0] dst);
    if (me[0] != dst[0]) begin
      next_hop = {me[1], dst[0]}; // R15
    end else begin
      next_hop = dst;
    end
  endfunction

  // ---------------- register file ----------------
  pad_cfg_type         phy_lo_r, phy_lo_nxt;
  pad_cfg_type         phy_hi_r, phy_hi_nxt;
  logic [31:0]         reconn_r, reconn_nxt;
  logic [15:0]         cdr_ctrl_r, cdr_ctrl_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [31:0]         status_word;

  // reserved bits are never stored, so they read back as zero
  always_comb begin
    phy_lo_nxt   = phy_lo_r;
    phy_hi_nxt   = phy_hi_r;
    reconn_nxt   = reconn_r;
    cdr_ctrl_nxt = cdr_ctrl_r;
    rdata_nxt    = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        PHY_LO_OFF:    phy_lo_nxt   = word_to_pad(i_wdata); // R19
        PHY_HI_OFF:    phy_hi_nxt   = word_to_pad(i_wdata); // R01
        RECONNECT_OFF: reconn_nxt   = i_wdata;
        CDR_CTRL_OFF:  cdr_ctrl_nxt = i_wdata[15:0];
        default:       ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        PHY_LO_OFF:    rdata_nxt = pad_to_word(phy_lo_r) & PHY_MASK;
        PHY_HI_OFF:    rdata_nxt = pad_to_word(phy_hi_r) & PHY_MASK;
        RECONNECT_OFF: rdata_nxt = reconn_r;
        CDR_CTRL_OFF:  rdata_nxt = {16'h0000, cdr_ctrl_r} & CDR_MASK;
        STATUS_OFF:    rdata_nxt = status_word;
        default:       rdata_nxt = 32'h0000_0000; // R19
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phy_lo_r   <= pad_cfg_type'({PHY_RESET[31:20], PHY_RESET[16:12]});
      phy_hi_r   <= pad_cfg_type'({PHY_RESET[31:20], PHY_RESET[16:12]});
      reconn_r   <= 32'h0000_0000;
      cdr_ctrl_r <= 16'h0000;
      rdata_r    <= 32'h0000_0000;
    end else if (i_ce) begin
      phy_lo_r   <= phy_lo_nxt;
      phy_hi_r   <= phy_hi_nxt;
      reconn_r   <= reconn_nxt;
      cdr_ctrl_r <= cdr_ctrl_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // ---------------- pad drive ----------------
  // pads are registered so a mode change never glitches the pad lines
  pad_cfg_type         pad_lo_r, pad_lo_nxt;
  pad_cfg_type         pad_hi_r, pad_hi_nxt;

  always_comb begin
    pad_lo_nxt = phy_lo_r; // R05 R06 R07
    pad_hi_nxt = i_wide_mode ? phy_lo_r : phy_hi_r; // R01 R02
    // older protocol: clock pad is forced to the external source
    if (i_legacy_mode) begin
      pad_lo_nxt.clk_sel_pll = 1'b0; // R03
      pad_hi_nxt.clk_sel_pll = 1'b0; // R03
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pad_lo_r <= pad_cfg_type'({PHY_RESET[31:20], PHY_RESET[16:12]});
      pad_hi_r <= pad_cfg_type'({PHY_RESET[31:20], PHY_RESET[16:12]});
    end else if (i_ce) begin
      pad_lo_r <= pad_lo_nxt;
      pad_hi_r <= pad_hi_nxt;
    end
  end

  // dll_sel_ext passes straight: 1 = external, opposite sense of bit 29
  assign o_pad_lo = pad_lo_r; // R04
  assign o_pad_hi = pad_hi_r; // R04

  // ---------------- link domain: CDR lock and done ----------------
  logic                lock_link_r;
  logic                done_meta_r;
  logic                done_link_r;
  logic                cdr_state_done;

  // link-side flops ignore i_ce: the PHY clock side never pauses
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_link_r <= 1'b0;
      done_meta_r <= 1'b0;
      done_link_r <= 1'b0;
    end else begin
      lock_link_r <= i_phy_cdr_lock;
      done_meta_r <= cdr_state_done;
      done_link_r <= done_meta_r;
    end
  end

  assign o_link_cdr_done = done_link_r;

  // ---------------- CDR wait ----------------
  logic                lock_meta_r, lock_sync_r;
  cdr_state_type       cdr_state_r, cdr_state_nxt;
  logic [CDR_LIM_W-1:0] cdr_cnt_r, cdr_cnt_nxt;
  logic                cdr_ignore;
  logic [CDR_LIM_W-1:0] cdr_limit;
  logic                cdr_done_r, cdr_done_nxt;

  assign cdr_ignore = cdr_ctrl_r[CDR_IGN_BIT];
  assign cdr_limit  = cdr_ctrl_r[CDR_LIM_W-1:0];

  always_comb begin
    cdr_state_nxt = cdr_state_r;
    cdr_cnt_nxt   = cdr_cnt_r;
    case (cdr_state_r)
      CDR_IDLE: begin
        if (i_init_start) begin
          cdr_cnt_nxt   = '0;
          // older protocol has no CDR phase
          cdr_state_nxt = i_legacy_mode ? CDR_DONE : CDR_WAIT; // R08
        end
      end
      CDR_WAIT: begin
        // a start seen here is dropped; software waits for done first
        // counter parks at the limit so a lock-mode wait cannot wrap
        if (cdr_cnt_r != cdr_limit) begin
          cdr_cnt_nxt = cdr_cnt_r + 1'b1; // R10
        end
        if (cdr_ignore ? (cdr_cnt_r == cdr_limit)
                       : lock_sync_r) begin
          cdr_state_nxt = CDR_DONE; // R09
        end
      end
      CDR_DONE: begin
        if (i_init_start) begin
          cdr_cnt_nxt   = '0;
          cdr_state_nxt = i_legacy_mode ? CDR_DONE : CDR_WAIT;
        end
      end
      default: cdr_state_nxt = CDR_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
      cdr_state_r <= CDR_IDLE;
      cdr_cnt_r   <= '0;
      cdr_done_r  <= 1'b0;
    end else if (i_ce) begin
      lock_meta_r <= lock_link_r;
      lock_sync_r <= lock_meta_r;
      cdr_state_r <= cdr_state_nxt;
      cdr_cnt_r   <= cdr_cnt_nxt;
      cdr_done_r  <= cdr_done_nxt;
    end
  end

  // done kept in its own flop: the link-side synchroniser must see a
  // flop output, not a decode of state bits that may glitch
  assign cdr_done_nxt   = (cdr_state_nxt == CDR_DONE);
  assign cdr_state_done = cdr_done_r;
  assign o_cdr_done     = cdr_state_done;

  // ---------------- reconnect timers ----------------
  logic                ldt_meta_r, ldt_sync_r, ldt_prev_r;
  logic                ldt_fall;
  logic [1:0]          wait_busy;
  logic [1:0]          wait_done;

  // edge detector starts low, so the pin idling high after reset
  // is never taken as a fall
  // only a configured frequency change arms the timers
  assign ldt_fall = ldt_prev_r & ~ldt_sync_r & i_soft_freq_en; // R18

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ldt_meta_r <= 1'b0;
      ldt_sync_r <= 1'b0;
      ldt_prev_r <= 1'b0;
    end else if (i_ce) begin
      ldt_meta_r <= i_ldt_active;
      ldt_sync_r <= ldt_meta_r;
      ldt_prev_r <= ldt_sync_r;
    end
  end

  // index 0 transmit side, index 1 receive side
  for (genvar g = 0; g < 2; g++) begin : g_wait
    logic [WAIT_W-1:0] cnt_r, cnt_nxt;
    logic              busy_r, busy_nxt;
    logic              done_r, done_nxt;
    logic [WAIT_W-1:0] load;

    assign load = reconn_r[g*RX_WAIT_LSB +: WAIT_W]; // R12 R13

    always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      // a fresh fall reloads both timers even in mid-count
      if (ldt_fall) begin
        cnt_nxt  = load;
        busy_nxt = 1'b1;
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1; // R11
        end else begin
          cnt_nxt = cnt_r - 1'b1; // R11
        end
      end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        cnt_r  <= '0;
        busy_r <= 1'b0;
        done_r <= 1'b0;
      end else if (i_ce) begin
        cnt_r  <= cnt_nxt;
        busy_r <= busy_nxt;
        done_r <= done_nxt;
      end
    end

    assign wait_busy[g] = busy_r;
    assign wait_done[g] = done_r;
  end

  assign o_tx_reconnect_done = wait_done[0];
  assign o_rx_reconnect_done = wait_done[1];

  assign status_word = {26'h0, wait_busy, lock_sync_r,
                        cdr_state_r};

  // ---------------- configuration window ----------------
  cfg_req_type         cfg_r, cfg_nxt;

  always_comb begin
    cfg_nxt       = cfg_r;
    cfg_nxt.valid = 1'b0;
    if (i_cpu_req && i_cpu_addr >= CFG_WIN_LO
        && i_cpu_addr <= CFG_WIN_HI) begin
      cfg_nxt.valid = 1'b1; // R14
      // bus number zero means type 0, any other bus type 1
      cfg_nxt.type1 = (i_cpu_addr[CFG_BUS_LSB +: 8] != 8'h00); // R14
      cfg_nxt.addr  = i_cpu_addr[CFG_ADDR_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r <= '0;
    end else if (i_ce) begin
      cfg_r <= cfg_nxt;
    end
  end

  assign o_cfg_req = cfg_r;

  // ---------------- routing ----------------
  // outputs hold until the next request, so a hop can be read late
  logic [1:0]          next_r, next_nxt;
  logic                local_r, local_nxt;
  logic                high_r, high_nxt;
  logic                master_r;

  always_comb begin
    next_r_hold:
    begin
      next_nxt  = next_r;
      local_nxt = local_r;
      high_nxt  = high_r;
      if (i_route_req) begin
        next_nxt  = next_hop(i_my_id, i_dst_id); // R15 R16
        local_nxt = (i_my_id == i_dst_id);
        // X hops use the low half, Y hops the high half
        high_nxt  = (i_my_id[0] == i_dst_id[0]) &&
                    (i_my_id != i_dst_id); // R17
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      next_r   <= 2'h0;
      local_r  <= 1'b0;
      high_r   <= 1'b0;
      master_r <= 1'b0;
    end else if (i_ce) begin
      next_r   <= next_nxt;
      local_r  <= local_nxt;
      high_r   <= high_nxt;
      master_r <= 1'b1; // R17
    end
  end

  assign o_next_id         = next_r;
  assign o_route_local     = local_r;
  assign o_route_high_half = high_r;
  assign o_low_half_master = master_r;

endmodule

// ---- link_phy_pkg.sv ----
// constants and types for the link PHY / init configuration bank
// assumes a 100 MHz controller clock and a separate link clock
// Notes on behaviour
// R01 - split mode: each half from own register
// R02 - wide mode: both halves from low register
// R03 - bit 29 picks data pad clock source
// R04 - bit 28 picks DLL lock clock source
// R05 - bits 31/30 enable rx/tx clock termination
// R06 - three 2-bit equalizer fields drive pads
// R07 - bits 16:12 pre-emphasis to transmit pads
// R08 - newer mode: CDR done by lock or count
// R09 - bit 15 selects count instead of lock
// R10 - bits 14:0 limit the CDR wait counter
// R11 - time reconnect after frequency change
// R12 - bits 31:16 load receive reconnect counter
// R13 - bits 15:0 load transmit reconnect counter
// R14 - config window access becomes type 0/1
// R15 - route fixes X bit, then Y bit
// R16 - 11 to 00 via 10, back via 01
// R17 - low half master, high half slave
// R18 - frequency change needs enable then disconnect
// R19 - reserved bits read zero, ignore writes
package link_phy_pkg;

  localparam logic [11:0] PHY_LO_OFF    = 12'h170;
  localparam logic [11:0] PHY_HI_OFF    = 12'h370;
  localparam logic [11:0] RECONNECT_OFF = 12'h184;
  localparam logic [11:0] CDR_CTRL_OFF  = 12'h188;
  localparam logic [11:0] STATUS_OFF    = 12'h18c;

  localparam logic [31:0] PHY_RESET     = 32'h8330_8000;
  localparam logic [31:0] PHY_MASK      = 32'hfff1_f000;
  localparam logic [31:0] CDR_MASK      = 32'h0000_ffff;
  localparam int          CDR_IGN_BIT   = 15;
  localparam int          CDR_LIM_W     = 15;
  localparam int          WAIT_W        = 16;
  localparam int          RX_WAIT_LSB   = 16;

  localparam logic [39:0] CFG_WIN_LO    = 40'hfd_fe00_0000;
  localparam logic [39:0] CFG_WIN_HI    = 40'hfd_ffff_ffff;
  localparam int          CFG_BUS_LSB   = 16;
  localparam int          CFG_ADDR_W    = 24;

  typedef struct packed {
    logic       term_rx;
    logic       term_tx;
    logic       clk_sel_pll;
    logic       dll_sel_ext;
    logic [1:0] eq_high_freq_gain;
    logic [1:0] eq_low_freq_gain;
    logic [1:0] eq_comp_limit;
    logic       ldo_en;
    logic       bandgap_en;
    logic [4:0] preemph;
  } pad_cfg_type;

  typedef struct packed {
    logic                  valid;
    logic                  type1;
    logic [CFG_ADDR_W-1:0] addr;
  } cfg_req_type;

  typedef enum logic [2:0] {
    CDR_IDLE = 3'b001,
    CDR_WAIT = 3'b010,
    CDR_DONE = 3'b100
  } cdr_state_type;

endpackage

// ---- link_phy_props.sv ----
// port checker for link_phy_init_config
// assumes i_ce high whenever bus, cpu or route inputs are active
`timescale 1ns/10ps
module link_phy_props
  import link_phy_pkg::*;
(
  // watched ports
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic [11:0] i_addr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_wide_mode,
  input wire logic        i_legacy_mode,
  input wire pad_cfg_type o_pad_lo,
  input wire pad_cfg_type o_pad_hi,
  input wire logic        i_init_start,
  input wire logic        o_cdr_done,
  input wire logic        o_rx_reconnect_done,
  input wire logic        i_cpu_req,
  input wire logic [39:0] i_cpu_addr,
  input wire cfg_req_type o_cfg_req,
  input wire logic        i_route_req,
  input wire logic [1:0]  i_my_id,
  input wire logic [1:0]  i_dst_id,
  input wire logic [1:0]  o_next_id,
  input wire logic        o_route_local,
  input wire logic        o_route_high_half,
  input wire logic        o_low_half_master
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic inwin;
  logic mapped;
  assign inwin = i_cpu_addr >= CFG_WIN_LO && i_cpu_addr <= CFG_WIN_HI;
  assign mapped = i_addr inside {PHY_LO_OFF, PHY_HI_OFF, RECONNECT_OFF,
                                 CDR_CTRL_OFF, STATUS_OFF};
  a_rd_unmapped: assert property (i_rd && !mapped |=> o_rdata == '0)
    else $error("unmapped read not zero");
  a_wide_pads: assert property (i_wide_mode && $past(i_wide_mode) |->
    o_pad_hi == o_pad_lo) else $error("wide pads differ");
  a_legacy_clksel: assert property ($past(i_legacy_mode) |->
    !o_pad_lo.clk_sel_pll) else $error("legacy clock pad wrong");
  a_cfg_inside: assert property (i_cpu_req && inwin |=> o_cfg_req.valid
    && o_cfg_req.type1 == ($past(i_cpu_addr[23:16]) != 0)
    && o_cfg_req.addr == $past(i_cpu_addr[23:0]))
    else $error("config request wrong");
  a_cfg_outside: assert property (!(i_cpu_req && inwin) |=>
    !o_cfg_req.valid) else $error("spurious config request");
  a_route_xfirst: assert property (i_route_req && i_my_id[0] != i_dst_id[0]
    |=> o_next_id == {$past(i_my_id[1]), $past(i_dst_id[0])}
    && !o_route_high_half) else $error("x hop wrong");
  a_route_yhop: assert property (i_route_req && i_my_id[0] == i_dst_id[0]
    && i_my_id[1] != i_dst_id[1] |=> o_next_id == $past(i_dst_id)
    && o_route_high_half) else $error("y hop wrong");
  a_route_local: assert property (i_route_req && i_my_id == i_dst_id
    |=> o_route_local) else $error("local route missed");
  a_cdr_hold: assert property (o_cdr_done && !i_init_start |=> o_cdr_done)
    else $error("cdr done dropped");
  a_rx_pulse: assert property (o_rx_reconnect_done |=>
    !o_rx_reconnect_done) else $error("reconnect pulse too long");
  a_low_master: assert property ($past(i_nrst) |-> o_low_half_master)
    else $error("low half not master");
  c_cfg: cover property (i_cpu_req && inwin);
  c_cdr: cover property ($rose(o_cdr_done));
  c_yhop: cover property (o_route_high_half);
endmodule
bind link_phy_init_config link_phy_props u_props (.i_clk, .i_nrst, .i_addr,
  .i_rd, .o_rdata, .i_wide_mode, .i_legacy_mode, .o_pad_lo, .o_pad_hi,
  .i_init_start, .o_cdr_done, .o_rx_reconnect_done, .i_cpu_req,
  .i_cpu_addr, .o_cfg_req, .i_route_req, .i_my_id, .i_dst_id, .o_next_id,
  .o_route_local, .o_route_high_half, .o_low_half_master);

// ---- peer_link.sv ----
// peer controller model: cdr lock and link-down pin seen by the device
// assumes the bench tells it when to lock and when to disconnect
`timescale 1ns/10ps
module peer_link (
  // link side
  input  wire logic i_link_clk,
  input  wire logic i_go,
  input  wire logic i_drop,
  output logic      o_lock,
  output logic      o_ldt
);
  logic [1:0] dly_r;
  initial begin
    dly_r = '0;
    o_lock = 1'b0;
    o_ldt = 1'b1;
  end
  // lock lags the go request, as a real cdr needs time
  always @(posedge i_link_clk) begin
    dly_r <= {dly_r[0], i_go};
    o_lock <= dly_r[1];
    o_ldt <= !i_drop;
  end
endmodule

// ---- testbench.sv ----
// self-checking bench for link_phy_init_config
// assumes the peer_link model on the link side
`timescale 1ns/10ps
module testbench
  import link_phy_pkg::*;
;
  logic i_clk = 0, i_nrst = 0, i_ce = 1, i_link_clk = 0;
  logic [11:0] i_addr = '0;
  logic [31:0] i_wdata = '0, o_rdata, lo, hi;
  logic i_wr = 0, i_rd = 0, i_wide_mode = 0, i_legacy_mode = 0;
  logic i_soft_freq_en = 0, i_init_start = 0, i_phy_cdr_lock, i_ldt_active;
  logic o_cdr_done, o_link_cdr_done, o_rx_reconnect_done;
  logic o_tx_reconnect_done, i_cpu_req = 0, i_route_req = 0;
  logic [39:0] i_cpu_addr = '0, a;
  logic [1:0] i_my_id = '0, i_dst_id = '0, o_next_id, nx;
  logic o_route_local, o_route_high_half, o_low_half_master;
  logic lock_go = 0, drop = 0;
  pad_cfg_type o_pad_lo, o_pad_hi;
  cfg_req_type o_cfg_req;
  int err_total = 0, comparisons = 0, cyc = 0, n, t, r, tx, rx;
  link_phy_init_config DUT (.*);
  peer_link peer (.i_link_clk, .i_go(lock_go), .i_drop(drop),
                  .o_lock(i_phy_cdr_lock), .o_ldt(i_ldt_active));
  initial forever #5 i_clk = ~i_clk;
  initial begin
    #3;
    forever #62.5 i_link_clk = ~i_link_clk;
  end
  task conclude;
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      conclude;
    end
  end
  task chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {ad, d, 1'b1};
    @(posedge i_clk) i_wr <= 0;
  endtask
  task rd(input logic [11:0] ad, input logic [31:0] e);
    @(posedge i_clk) {i_addr, i_rd} <= {ad, 1'b1};
    @(posedge i_clk) i_rd <= 0;
    #1 chk(o_rdata, e);
  endtask
  task automatic step(output int k, ref logic s);
    k = 0;
    while (s !== 1 && k < 200) begin
      @(posedge i_clk);
      #1 k++;
    end
  endtask
  function automatic logic [16:0] pad(input logic [31:0] v);
    return {v[31:20], v[16:12]};
  endfunction
  initial begin
    void'($urandom(41774));
    repeat (20) @(posedge i_clk);
    i_nrst <= 1;
    rd(PHY_LO_OFF, PHY_RESET);
    rd(PHY_HI_OFF, PHY_RESET);
    rd(RECONNECT_OFF, 0);
    rd(CDR_CTRL_OFF, 0);
    chk(o_pad_lo, pad(PHY_RESET));
    chk(o_low_half_master, 1);
    lo = $urandom;
    hi = $urandom;
    wr(PHY_LO_OFF, lo);
    wr(PHY_HI_OFF, hi);
    wr(12'h100, hi);
    rd(PHY_LO_OFF, lo & PHY_MASK);
    rd(12'h100, 0);
    chk(o_pad_lo, pad(lo));
    chk(o_pad_hi, pad(hi));
    @(posedge i_clk) {i_wide_mode, i_legacy_mode} <= 2'b11;
    repeat (2) @(posedge i_clk);
    #1 chk(o_pad_hi, pad(lo) & 17'h1bfff);
    chk(o_pad_lo, pad(lo) & 17'h1bfff);
    @(posedge i_clk) {i_wide_mode, i_legacy_mode} <= 2'b00;
    for (int j = 0; j < 3; j++) begin
      tx = (j == 0) ? 0 : $urandom_range(1, 40);
      wr(CDR_CTRL_OFF, 32'h8000 | tx);
      @(posedge i_clk) i_init_start <= 1;
      @(posedge i_clk) i_init_start <= 0;
      #1 step(n, o_cdr_done);
      chk(n, tx + 1);
    end
    wr(CDR_CTRL_OFF, 5);
    @(posedge i_clk) i_init_start <= 1;
    @(posedge i_clk) i_init_start <= 0;
    repeat (30) @(posedge i_clk);
    #1 chk(o_cdr_done, 0);
    lock_go = 1;
    step(n, o_cdr_done);
    chk(o_cdr_done, 1);
    step(n, o_link_cdr_done);
    chk(o_link_cdr_done, 1);
    tx = $urandom_range(2, 20);
    rx = tx + $urandom_range(1, 20);
    wr(RECONNECT_OFF, {rx[15:0], tx[15:0]});
    rd(RECONNECT_OFF, {rx[15:0], tx[15:0]});
    @(posedge i_clk) i_ce <= 0;
    wr(RECONNECT_OFF, 32'h0000_0000);
    @(posedge i_clk) i_ce <= 1;
    rd(RECONNECT_OFF, {rx[15:0], tx[15:0]});
    for (int e = 1; e >= 0; e--) begin
      @(posedge i_clk) i_soft_freq_en <= e[0];
      drop = 1;
      t = -1;
      r = -1;
      for (n = 0; n < 150; n++) begin
        @(posedge i_clk);
        #1 if (o_tx_reconnect_done === 1) t = n;
        if (o_rx_reconnect_done === 1) r = n;
      end
      if (e) chk(r - t, rx - tx);
      else begin
        chk(r, -1);
        chk(t, -1);
      end
      drop = 0;
      repeat (40) @(posedge i_clk);
    end
    for (int j = 0; j < 5; j++) begin
      a = (j == 0) ? CFG_WIN_LO : (j == 1) ? CFG_WIN_HI : (j == 2) ?
          CFG_WIN_LO - 1 : (j == 3) ? CFG_WIN_HI + 1 :
          CFG_WIN_LO + $urandom_range(0, 32'h1ffffff);
      @(posedge i_clk) {i_cpu_req, i_cpu_addr} <= {1'b1, a};
      @(posedge i_clk) i_cpu_req <= 0;
      #1 chk(o_cfg_req.valid, a >= CFG_WIN_LO && a <= CFG_WIN_HI);
      if (o_cfg_req.valid === 1)
        chk({o_cfg_req.type1, o_cfg_req.addr}, {a[23:16] != 0, a[23:0]});
    end
    for (int j = 0; j < 16; j++) begin
      @(posedge i_clk) {i_route_req, i_my_id, i_dst_id} <= {1'b1, j[3:0]};
      @(posedge i_clk) i_route_req <= 0;
      nx = (j[2] != j[0]) ? {j[3], j[0]} : j[1:0];
      #1 chk({o_next_id, o_route_local, o_route_high_half},
             {nx, j[3:2] == j[1:0], j[2] == j[0] && j[3] != j[1]});
    end
    conclude;
  end
endmodule
